// ---- shared/rivp_pkg.sv ----
// rivp_pkg: constants and types for reset and interrupt vector placement
// assumes word-addressed program memory and a 32-bit AXI4-Lite register bus
package rivp_pkg;

    // ------------------------------------------------------------
    // program memory geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int NUM_SRC = 18;
    localparam int IDX_W = 5;
    localparam logic [12:0] FLASH_TOP = 13'h1000;
    localparam logic [12:0] BOOT_MIN_WORDS = 13'h0080;
    localparam logic [1:0] BOOT_SZ_MAX = 2'h3;

    // ------------------------------------------------------------
    // vector slots, relative to the table start
    // ------------------------------------------------------------
    localparam logic [11:0] RESET_VEC = 12'h000;
    localparam logic [11:0] VEC_EXT_IRQ_ZERO = 12'h001;
    localparam logic [11:0] VEC_EXT_IRQ_ONE = 12'h002;
    localparam logic [11:0] VEC_TIMER8B_ASYNC_COMPARE = 12'h003;
    localparam logic [11:0] VEC_TIMER8B_ASYNC_OVERFLOW = 12'h004;
    localparam logic [11:0] VEC_TIMER16_CAPTURE = 12'h005;
    localparam logic [11:0] VEC_TIMER16_COMPARE_A = 12'h006;
    localparam logic [11:0] VEC_TIMER16_COMPARE_B = 12'h007;
    localparam logic [11:0] VEC_TIMER16_OVERFLOW = 12'h008;
    localparam logic [11:0] VEC_TIMER8B_OVERFLOW = 12'h009;
    localparam logic [11:0] VEC_SPI_TRANSFER_DONE = 12'h00a;
    localparam logic [11:0] VEC_SERIAL_RX_DONE = 12'h00b;
    localparam logic [11:0] VEC_SERIAL_TX_EMPTY = 12'h00c;
    localparam logic [11:0] VEC_SERIAL_TX_DONE = 12'h00d;
    localparam logic [11:0] VEC_ADC_DONE = 12'h00e;
    localparam logic [11:0] VEC_NVDATA_READY = 12'h00f;
    localparam logic [11:0] VEC_COMPARATOR = 12'h010;
    localparam logic [11:0] VEC_TWO_WIRE_SERIAL = 12'h011;
    localparam logic [11:0] VEC_SELFPROG_READY = 12'h012;

    // ------------------------------------------------------------
    // fuse encoding and timing
    // ------------------------------------------------------------
    localparam logic FUSE_PROGRAMMED = 1'b0;
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam logic [1:0] FUSE_SETTLE = 2'h2;

    // ------------------------------------------------------------
    // register map and fields
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_MASK = 4'h8;
    localparam logic [3:0] OFF_INFO = 4'hc;
    localparam int CTRL_UNLOCK_BIT = 0;
    localparam int CTRL_SELECT_BIT = 1;
    localparam int EV_W = 3;
    localparam int EV_MOVED = 0;
    localparam int EV_EXPIRED = 1;
    localparam int EV_DISPATCH = 2;
    localparam int INFO_BASE_LSB = 16;
    localparam int INFO_HOLD_BIT = 31;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // unlock sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OPEN = 3'b010,
        ST_HOLD = 3'b100
    } rivp_state_t;

    // boot section start from the boot size fuse code
    function automatic logic [11:0] boot_start(input logic [1:0] sz);
        logic [12:0] words;
        words = BOOT_MIN_WORDS << (BOOT_SZ_MAX - sz);
        return 12'(FLASH_TOP - words);
    endfunction : boot_start

endpackage : rivp_pkg

// ---- core/rivp_prio.sv ----
// rivp_prio: picks the pending source with the lowest vector number
// assumes request lines already on mclk
`timescale 1ns/1ps
`default_nettype none
module rivp_prio #(
    parameter int NSRC = rivp_pkg::NUM_SRC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [NSRC-1:0] req,
    output logic any,
    output logic [rivp_pkg::IDX_W-1:0] idx
);
    // lowest set bit wins
    function automatic logic [rivp_pkg::IDX_W-1:0] lowest(input logic [NSRC-1:0] r);
        logic [rivp_pkg::IDX_W-1:0] k;
        k = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (r[i]) begin
                k = rivp_pkg::IDX_W'(i);
            end
        end
        return k;
    endfunction : lowest

    // request summary and winner
    assign any = |req;
    assign idx = lowest(req);

    a_prio_lowest: assert property (@(posedge mclk) disable iff (!nrst)
        any |-> (req[idx] && ((req & ((NSRC'(1) << idx) - NSRC'(1))) == '0)))
        else $error("winner is not the lowest pending source");
endmodule : rivp_prio
`default_nettype wire

// ---- core/rivp_unlock.sv ----
// rivp_unlock: timed unlock sequence for the vector table select bit
// assumes one write strobe per register write and a cpu instruction-done pulse
`timescale 1ns/1ps
`default_nettype none
module rivp_unlock (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic wr_unlock,
    input wire logic wr_select,
    input wire logic instr_done,
    output logic select_ff,
    output logic unlock_ff,
    output logic holdoff,
    output logic moved,
    output logic expired
);
    rivp_pkg::rivp_state_t state_ff, nxt_state;
    logic [2:0] cnt_ff, nxt_cnt;
    logic nxt_select;
    wire arm = wr_en && wr_unlock;
    wire commit = wr_en && !wr_unlock && (state_ff == rivp_pkg::ST_OPEN);
    wire timeout = (state_ff == rivp_pkg::ST_OPEN) && (cnt_ff == 3'h1);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_select = select_ff;
        case (state_ff)
            rivp_pkg::ST_OPEN: begin
                nxt_cnt = cnt_ff - 3'h1;
                if (arm) begin
                    nxt_cnt = rivp_pkg::UNLOCK_CYCLES; // rewrite restarts window
                end else if (commit) begin
                    nxt_select = wr_select;
                    nxt_state = rivp_pkg::ST_HOLD;
                end else if (timeout) begin
                    nxt_state = rivp_pkg::ST_IDLE;
                end
            end
            rivp_pkg::ST_HOLD: begin
                if (arm) begin
                    nxt_state = rivp_pkg::ST_OPEN;
                    nxt_cnt = rivp_pkg::UNLOCK_CYCLES;
                end else if (instr_done) begin
                    nxt_state = rivp_pkg::ST_IDLE;
                end
            end
            default: begin
                if (arm) begin
                    nxt_state = rivp_pkg::ST_OPEN;
                    nxt_cnt = rivp_pkg::UNLOCK_CYCLES;
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            state_ff <= rivp_pkg::ST_IDLE;
            cnt_ff <= 3'h0;
            select_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            select_ff <= nxt_select;
        end
    end

    // outputs decoded from state and the current control write
    assign unlock_ff = (state_ff == rivp_pkg::ST_OPEN);
    assign holdoff = (state_ff != rivp_pkg::ST_IDLE) || arm;
    assign moved = commit;
    assign expired = timeout && !arm;

    sequence s_arm;
        wr_en && wr_unlock;
    endsequence
    sequence s_quiet4;
        !wr_en [*4];
    endsequence

    a_unlock_expire: assert property (@(posedge mclk) disable iff (!nrst)
        s_arm ##1 s_quiet4 |=> !unlock_ff)
        else $error("unlock bit still set after four cycles");
    a_unlock_open: assert property (@(posedge mclk) disable iff (!nrst)
        s_arm |=> unlock_ff)
        else $error("unlock bit not set by the unlock write");
    a_select_guard: assert property (@(posedge mclk) disable iff (!nrst)
        !unlock_ff |=> $stable(select_ff))
        else $error("select changed without unlock");
    a_hold_window: assert property (@(posedge mclk) disable iff (!nrst)
        (commit && !instr_done) |=> holdoff)
        else $error("interrupts not held after select write");
endmodule : rivp_unlock
`default_nettype wire

// ---- core/rivp_top.sv ----
// rivp_top: reset and interrupt vector placement with AXI4-Lite registers
// assumes fuse pins are static straps from outside the mclk domain,
// peripheral request lines and cpu strobes are synchronous to mclk
//
// Function
// - fuse unprogrammed: every reset cause starts at word 0x000
// - nineteen vectors sit in consecutive slots 0x000 to 0x012
// - external request zero at slot 0x001, one at 0x002
// - 16-bit timer capture, compare a, compare b, overflow at 0x005..0x008
// - serial rx done 0x00b, tx empty 0x00c, tx done 0x00d
// - two-wire serial at 0x011, self-programming ready at 0x012
// - fuse programmed: every reset starts at the boot loader start
// - select set: vector equals slot plus boot section start
// - reset address follows only the boot reset and boot size fuses
// - first vector 0x001, or boot start plus 0x001 when selected
// - boot reset fuse reads 1 unprogrammed, 0 programmed
// - undispatched slots stay ordinary program memory for fetch
// - select changes only within four cycles after an unlock write
// - unlock clears four cycles after writing or on select write
// - interrupts held off during the sequence, global flag untouched
// - boot section start comes from the boot size fuses
`timescale 1ns/1ps
`default_nettype none
module rivp_top #(
    parameter int NSRC = rivp_pkg::NUM_SRC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic boot_reset_fuse,
    input wire logic [1:0] boot_size_fuses,
    input wire logic [NSRC-1:0] irq_req,
    input wire logic cpu_gie,
    input wire logic cpu_instr_done,
    input wire logic cpu_irq_ack,
    output logic cpu_irq_req,
    output logic [rivp_pkg::ADDR_W-1:0] reset_addr,
    output logic [rivp_pkg::ADDR_W-1:0] vec_addr,
    output logic [rivp_pkg::IDX_W-1:0] vec_num,
    output logic vec_valid,
    output logic irq
);
    localparam int AW = rivp_pkg::ADDR_W;
    localparam int IW = rivp_pkg::IDX_W;
    localparam int EW = rivp_pkg::EV_W;

    // ------------------------------------------------------------
    // fuse synchronisers and capture after reset
    // ------------------------------------------------------------
    logic [2:0] fuse_meta_ff;
    logic [2:0] fuse_sync_ff;
    logic [1:0] settle_ff;
    logic fuse_rst_ff;
    logic [1:0] fuse_sz_ff;
    logic cap_done_ff;

    // two-stage sync of the strap levels
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            fuse_meta_ff <= 3'h7;
            fuse_sync_ff <= 3'h7;
        end else begin
            fuse_meta_ff <= {boot_reset_fuse, boot_size_fuses};
            fuse_sync_ff <= fuse_meta_ff;
        end
    end

    // capture fuses once the synchroniser has filled
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            settle_ff <= 2'h0;
            cap_done_ff <= 1'b0;
            fuse_rst_ff <= 1'b1;
            fuse_sz_ff <= 2'h0;
        end else if (!cap_done_ff) begin
            settle_ff <= settle_ff + 2'h1;
            if (settle_ff == rivp_pkg::FUSE_SETTLE) begin
                cap_done_ff <= 1'b1;
                fuse_rst_ff <= fuse_sync_ff[2];
                fuse_sz_ff <= fuse_sync_ff[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // placement of reset and vector table
    // ------------------------------------------------------------
    logic select_ff;
    logic unlock_ff;
    logic holdoff;
    logic moved;
    logic expired;
    wire [AW-1:0] boot_addr = rivp_pkg::boot_start(fuse_sz_ff);
    wire fuse_prog = (fuse_rst_ff == rivp_pkg::FUSE_PROGRAMMED);
    wire [AW-1:0] rst_addr_nxt = fuse_prog ? boot_addr : rivp_pkg::RESET_VEC;
    wire [AW-1:0] tbl_base = select_ff ? boot_addr : rivp_pkg::RESET_VEC;

    // reset address register, independent of the select bit
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            reset_addr <= rivp_pkg::RESET_VEC;
        end else begin
            reset_addr <= rst_addr_nxt;
        end
    end

    // ------------------------------------------------------------
    // source arbitration and dispatch
    // ------------------------------------------------------------
    logic src_any;
    logic [IW-1:0] src_idx;

    rivp_prio #(
        .NSRC(NSRC)
    ) u_prio (
        .mclk(mclk),
        .nrst(nrst),
        .req(irq_req),
        .any(src_any),
        .idx(src_idx)
    );

    // slot of source index i is i+1, so the table is one slot per source
    wire [AW-1:0] slot = AW'(src_idx) + rivp_pkg::VEC_EXT_IRQ_ZERO;
    wire [AW-1:0] disp_addr = tbl_base + slot;
    // gie is only read, never driven from here
    assign cpu_irq_req = src_any && cpu_gie && !holdoff && cap_done_ff;
    wire dispatch = cpu_irq_req && cpu_irq_ack;

    // vector handed out only on an accepted interrupt; otherwise fetch is free
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            vec_addr <= rivp_pkg::RESET_VEC;
            vec_num <= '0;
            vec_valid <= 1'b0;
        end else begin
            vec_valid <= dispatch;
            if (dispatch) begin
                vec_addr <= disp_addr;
                vec_num <= src_idx;
            end
        end
    end

    // ------------------------------------------------------------
    // register bus: write path
    // ------------------------------------------------------------
    logic aw_have_ff;
    logic w_have_ff;
    logic [3:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic w_lo_ff;
    logic [EW-1:0] status_ff;
    logic [EW-1:0] mask_ff;

    assign s_axi_awready = !aw_have_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_have_ff && !s_axi_bvalid;
    wire do_wr = aw_have_ff && w_have_ff && !s_axi_bvalid;
    wire wr_lo = do_wr && w_lo_ff;

    // write decode
    wire wr_ctrl = wr_lo && (aw_addr_ff == rivp_pkg::OFF_CTRL);
    wire wr_stat = wr_lo && (aw_addr_ff == rivp_pkg::OFF_STATUS);
    wire wr_mask = wr_lo && (aw_addr_ff == rivp_pkg::OFF_MASK);
    wire wr_hit = (aw_addr_ff == rivp_pkg::OFF_CTRL) ||
                  (aw_addr_ff == rivp_pkg::OFF_STATUS) ||
                  (aw_addr_ff == rivp_pkg::OFF_MASK) ||
                  (aw_addr_ff == rivp_pkg::OFF_INFO);

    // address and data capture, in either order
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            aw_addr_ff <= 4'h0;
            w_data_ff <= 32'h0;
            w_lo_ff <= 1'b0;
        end else if (do_wr) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_lo_ff <= s_axi_wstrb[0];
            end
        end
    end

    // write response
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rivp_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? rivp_pkg::RESP_OKAY : rivp_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // select bit and its timed unlock
    // ------------------------------------------------------------
    rivp_unlock u_unlock (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(wr_ctrl),
        .wr_unlock(w_data_ff[rivp_pkg::CTRL_UNLOCK_BIT]),
        .wr_select(w_data_ff[rivp_pkg::CTRL_SELECT_BIT]),
        .instr_done(cpu_instr_done),
        .select_ff(select_ff),
        .unlock_ff(unlock_ff),
        .holdoff(holdoff),
        .moved(moved),
        .expired(expired)
    );

    // ------------------------------------------------------------
    // event status, mask and interrupt line
    // ------------------------------------------------------------
    wire [EW-1:0] events = {dispatch, expired, moved};
    wire [EW-1:0] clr = wr_stat ? w_data_ff[EW-1:0] : '0;
    // a new event wins over a clear in the same cycle
    wire [EW-1:0] nxt_status = (status_ff & ~clr) | events;

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            status_ff <= '0;
            mask_ff <= '0;
        end else begin
            status_ff <= nxt_status;
            if (wr_mask) begin
                mask_ff <= w_data_ff[EW-1:0];
            end
        end
    end

    assign irq = |(status_ff & mask_ff);

    // ------------------------------------------------------------
    // register bus: read path
    // ------------------------------------------------------------
    wire [31:0] ctrl_rd = {30'h0, select_ff, unlock_ff};
    wire [31:0] info_rd = {holdoff, 3'h0, tbl_base, 4'h0, reset_addr};
    wire rd_hit = (s_axi_araddr == rivp_pkg::OFF_CTRL) ||
                  (s_axi_araddr == rivp_pkg::OFF_STATUS) ||
                  (s_axi_araddr == rivp_pkg::OFF_MASK) ||
                  (s_axi_araddr == rivp_pkg::OFF_INFO);
    logic [31:0] rd_mux;

    // read decode
    always_comb begin
        if (s_axi_araddr == rivp_pkg::OFF_CTRL) begin
            rd_mux = ctrl_rd;
        end else if (s_axi_araddr == rivp_pkg::OFF_STATUS) begin
            rd_mux = 32'(status_ff);
        end else if (s_axi_araddr == rivp_pkg::OFF_MASK) begin
            rd_mux = 32'(mask_ff);
        end else if (s_axi_araddr == rivp_pkg::OFF_INFO) begin
            rd_mux = info_rd;
        end else begin
            rd_mux = 32'h0;
        end
    end

    assign s_axi_arready = !s_axi_rvalid;

    // read data register
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= rivp_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_hit ? rivp_pkg::RESP_OKAY : rivp_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_accept;
        cpu_irq_req && cpu_irq_ack;
    endsequence

    a_reset_vector: assert property (@(posedge mclk) disable iff (!nrst)
        cap_done_ff |=> (reset_addr == (fuse_rst_ff ? rivp_pkg::RESET_VEC : boot_addr)))
        else $error("reset address does not follow the fuse");
    a_vector_base: assert property (@(posedge mclk) disable iff (!nrst)
        s_accept |=> vec_valid && (vec_addr == $past(tbl_base) + AW'($past(src_idx)) + 12'h001))
        else $error("vector address is not base plus slot");
    a_first_vector: assert property (@(posedge mclk) disable iff (!nrst)
        (s_accept and irq_req[0]) |=> (vec_addr == ($past(select_ff) ? boot_addr : 12'h000) + 12'h001))
        else $error("first vector misplaced");
    a_timer_slot: assert property (@(posedge mclk) disable iff (!nrst)
        (s_accept and (!select_ff && irq_req[4] && (irq_req[3:0] == 4'h0)))
        |=> vec_addr == rivp_pkg::VEC_TIMER16_CAPTURE)
        else $error("timer capture vector misplaced");
    a_last_slot: assert property (@(posedge mclk) disable iff (!nrst)
        (s_accept and (!select_ff && (irq_req == (NSRC'(1) << (NSRC - 1)))))
        |=> vec_addr == rivp_pkg::VEC_SELFPROG_READY)
        else $error("last vector misplaced");
    a_no_dispatch_hold: assert property (@(posedge mclk) disable iff (!nrst)
        holdoff |-> !cpu_irq_req ##1 !vec_valid)
        else $error("interrupt dispatched during hold-off");
    a_irq_level: assert property (@(posedge mclk) disable iff (!nrst)
        (moved && mask_ff[rivp_pkg::EV_MOVED]) |=> irq [*2])
        else $error("interrupt line not raised for a masked-in event");
    a_write_resp: assert property (@(posedge mclk) disable iff (!nrst)
        do_wr |=> s_axi_bvalid)
        else $error("write response missing");
endmodule : rivp_top
`default_nettype wire

// ---- test/rivp_cpu_model.sv ----
// rivp_cpu_model: cpu fetch side that accepts interrupts and paces instructions
// assumes the same mclk and nrst as the block under test
`timescale 1ns/1ps
`default_nettype none
module rivp_cpu_model (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cpu_irq_req,
    output logic cpu_irq_ack,
    output logic cpu_instr_done
);
    logic [1:0] phase_ff;
    // one instruction every four cycles; accept on odd phases only, so acks come fast or slow
    always_ff @(posedge mclk) begin
        phase_ff <= nrst ? phase_ff + 2'h1 : 2'h0;
        cpu_instr_done <= nrst && (phase_ff == 2'h3);
        cpu_irq_ack <= nrst && cpu_irq_req && phase_ff[0];
    end
endmodule : rivp_cpu_model
`default_nettype wire

// ---- test/tb_reset_and_irq_vector_placement.sv ----
// tb_reset_and_irq_vector_placement: directed scenarios for rivp_top
// assumes rivp_cpu_model answers the cpu side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((e) !== (s)) begin failures++; $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_reset_and_irq_vector_placement;
    localparam logic [11:0] BOOT = 12'he00; // boot start for size code 1
    int failures = 0;
    int n_checks = 0;
    logic mclk = 1'b0, nrst = 1'b0, boot_reset_fuse = 1'b1, cpu_gie = 1'b1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, boot_size_fuses = 2'h1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [17:0] irq_req = 18'h0;
    logic cpu_irq_req, cpu_irq_ack, cpu_instr_done, vec_valid, irq;
    logic [11:0] reset_addr, vec_addr;
    logic [4:0] vec_num;
    always #2.5 mclk = ~mclk;
    rivp_top i_dut (.mclk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .boot_reset_fuse, .boot_size_fuses,
        .irq_req, .cpu_gie, .cpu_instr_done, .cpu_irq_ack, .cpu_irq_req, .reset_addr, .vec_addr, .vec_num,
        .vec_valid, .irq);
    rivp_cpu_model i_cpu (.mclk, .nrst, .cpu_irq_req, .cpu_irq_ack, .cpu_instr_done);
    // -------------------------------------------------------------
    // bus tasks and helpers
    // -------------------------------------------------------------
    task automatic results();
        $display("failures %0d checks %0d", failures, n_checks);
        if (failures == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ah, wh, bh;
        logic [31:0] rd;
        logic [1:0] rs;
        if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        else {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        for (n = 0; n < 40; n++) begin
            @(negedge mclk);
            ah = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
            wh = s_axi_wvalid && s_axi_wready;
            bh = wr ? s_axi_bvalid : s_axi_rvalid;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge mclk);
            if (ah && wr) s_axi_awvalid <= 1'b0;
            if (ah && !wr) s_axi_arvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            if (bh) break;
        end
        if (n == 40) begin
            failures++;
            results();
        end
        `CHK("resp", er, rs)
        if (!wr) `CHK("rdata", d, rd)
    endtask : xfer
    task automatic chk_irq(input logic e);
        @(negedge mclk);
        `CHK("irq", e, irq)
        @(posedge mclk);
    endtask : chk_irq
    task automatic disp(input logic [17:0] r, input logic [11:0] ea, input logic [4:0] en);
        int n;
        irq_req <= r;
        for (n = 0; n < 40 && vec_valid !== 1'b1; n++) @(negedge mclk);
        if (n == 40) begin
            failures++;
            results();
        end
        `CHK("vec_addr", ea, vec_addr)
        `CHK("vec_num", en, vec_num)
        @(posedge mclk);
        irq_req <= 18'h0;
        repeat (6) @(posedge mclk);
    endtask : disp
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_reset(input logic f, input logic [11:0] ea);
        boot_reset_fuse <= f;
        nrst <= 1'b0;
        repeat (10) @(posedge mclk);
        nrst <= 1'b1;
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        `CHK("reset_addr", ea, reset_addr)
        @(posedge mclk);
    endtask : t_reset
    task automatic t_vec(input logic [11:0] base);
        for (int i = 0; i < 18; i++) disp(18'h1 << i, base + 12'(i) + 12'h001, 5'(i));
    endtask : t_vec
    task automatic t_prio();
        disp(18'h00030, 12'h005, 5'h04);
        disp(18'h20001, 12'h001, 5'h00);
    endtask : t_prio
    task automatic t_move();
        xfer(1'b1, 4'h0, 32'h2, 2'h0);
        xfer(1'b0, 4'h0, 32'h0, 2'h0);
        xfer(1'b1, 4'h0, 32'h1, 2'h0);
        xfer(1'b1, 4'h0, 32'h2, 2'h0);
        xfer(1'b0, 4'h0, 32'h2, 2'h0);
        chk_irq(1'b0);
        xfer(1'b1, 4'h8, 32'h1, 2'h0);
        chk_irq(1'b1);
        xfer(1'b1, 4'h4, 32'h1, 2'h0);
        chk_irq(1'b0);
        xfer(1'b1, 4'h6, 32'h0, 2'h2);
        xfer(1'b0, 4'h6, 32'h0, 2'h2);
        // unlock left to lapse: expired event, then a masked-in move raises irq
        xfer(1'b1, 4'h0, 32'h1, 2'h0);
        xfer(1'b0, 4'h0, 32'h3, 2'h0);
        repeat (4) @(posedge mclk);
        xfer(1'b0, 4'h0, 32'h2, 2'h0);
        xfer(1'b0, 4'h4, 32'h6, 2'h0);
        xfer(1'b1, 4'h0, 32'h1, 2'h0);
        xfer(1'b1, 4'h0, 32'h2, 2'h0);
        chk_irq(1'b1);
    endtask : t_move
    // main sequence, then the verdict
    initial begin
        t_reset(1'b1, 12'h000);
        t_vec(12'h000);
        t_prio();
        t_move();
        t_vec(BOOT);
        t_reset(1'b0, BOOT);
        results();
    end
endmodule : tb_reset_and_irq_vector_placement
`default_nettype wire
